//--- rtl/lsm_pkg.sv
// Package of constants and types for the logic slice shift, mux and carry block
package lsm_pkg;
    // Slice geometry
    localparam int LSM_LANES   = 4;      // Lookup tables per slice
    localparam int LSM_DEPTH   = 32;     // Bits of shift storage per lookup table
    localparam int LSM_TAP_W   = 5;      // Width of a tap select
    localparam int LSM_MUX_W   = 2;      // Select width of a 4:1 selector
    localparam int LSM_MUX_N   = 4;      // Data inputs of a 4:1 selector
    localparam int LSM_TOP_BIT = 31;     // Highest stored position
    // Register bus
    localparam int LSM_DATA_W  = 32;
    localparam int LSM_ADDR_W  = 32;
    localparam int LSM_DEC_W   = 8;      // Address bits decoded
    localparam logic [7:0]  LSM_ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  LSM_ADDR_STATUS = 8'h04;
    localparam logic [31:0] LSM_CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] LSM_RDATA_NONE  = 32'h0000_0000;
    localparam logic [1:0]  LSM_HTRANS_NONSEQ = 2'b10;
    localparam logic        LSM_HRESP_OKAY    = 1'b0;
    localparam int          LSM_HTRANS_ACTIVE = 1;   // Bit set for NONSEQ/SEQ

    // Source of the carry into the lowest position
    typedef enum logic [1:0] {
        LSM_INIT_ZERO       = 2'b00,
        LSM_INIT_ONE        = 2'b01,
        LSM_INIT_BYPASS_A   = 2'b10,
        LSM_INIT_FROM_BELOW = 2'b11
    } lsm_init_t;

    // Source of each lane's slice flip-flop
    localparam logic [1:0] LSM_FF_LUT    = 2'b00;
    localparam logic [1:0] LSM_FF_SUM    = 2'b01;
    localparam logic [1:0] LSM_FF_CARRY  = 2'b10;
    localparam logic [1:0] LSM_FF_BYPASS = 2'b11;

    // Control register layout
    typedef struct packed {
        logic [12:0] spare;          // Reads as zero
        logic [7:0]  ff_src;         // Two bits per lane
        logic        cascade_en;     // Chain the lane shift registers
        logic [3:0]  srl_mode;       // Lane main result from shift tap
        logic [3:0]  gen_from_lut;   // Generate from second result
        lsm_init_t   init_sel;       // Carry into position zero
    } lsm_ctrl_t;

    // Status register layout
    typedef struct packed {
        logic [18:0] spare;          // Reads as zero
        logic        cascade_last;   // Top stored bit of the last lane
        logic [3:0]  lane_q;         // Slice flip-flops
        logic [3:0]  carry;          // Per-position carry outputs
        logic [3:0]  sum;            // Sum outputs
    } lsm_stat_t;
endpackage

//--- rtl/lsm_slice.sv
// Logic slice: addressable shift registers, wide selectors, carry chain
`timescale 1ns/1ps

// Function
// - Enabled edge loads serial bit, shifts up
// - Cascade output carries bit shifted out
// - Five-bit tap select picks stored bit
// - Tap output follows select combinationally
// - Fixed tap N gives N+1 stages
// - Fixed tap changes only on shifts
// - Cascade output holds top stored bit
// - Each lookup table is a 4:1 selector
// - Two pair muxes combine two tables each
// - Quad mux combines both pair muxes
// - Four upward carry positions with sum XOR
// - Ten chain inputs, eight chain outputs
// - Propagate comes from lookup main result
// - Generate from second result or bypass
// - Initial carry zero, one, bypass A or carry in from below
// - Top carry drives upward carry output
// - Sums and per-position carries presented
// - Chain results registrable in slice flops
// - Shift storage ignores any reset
// - Four cascaded tables give 128 stages
module lsm_slice (
    // Clock and reset
    input  wire logic                                   i_clk,
    input  wire logic                                   i_rst_b,
    // AHB-Lite register slave
    input  wire logic                                   i_hsel,
    input  wire logic [lsm_pkg::LSM_ADDR_W-1:0]         i_haddr,
    input  wire logic [1:0]                             i_htrans,
    input  wire logic                                   i_hwrite,
    input  wire logic [2:0]                             i_hsize,
    input  wire logic [lsm_pkg::LSM_DATA_W-1:0]         i_hwdata,
    input  wire logic                                   i_hready,
    output      logic                                   o_hreadyout,
    output      logic [lsm_pkg::LSM_DATA_W-1:0]         o_hrdata,
    output      logic                                   o_hresp,
    // Shift storage
    input  wire logic                                   i_shift_en,
    input  wire logic [lsm_pkg::LSM_LANES-1:0]          i_shift_in,
    input  wire logic [lsm_pkg::LSM_LANES-1:0]
                      [lsm_pkg::LSM_TAP_W-1:0]          i_tap_sel,
    output      logic [lsm_pkg::LSM_LANES-1:0]          o_tap,
    output      logic                                   o_cascade_shift_out,
    // Lookup table selector inputs
    input  wire logic [lsm_pkg::LSM_LANES-1:0]
                      [lsm_pkg::LSM_MUX_N-1:0]          i_lut_data,
    input  wire logic [lsm_pkg::LSM_LANES-1:0]
                      [lsm_pkg::LSM_MUX_W-1:0]          i_lut_sel,
    input  wire logic [lsm_pkg::LSM_LANES-1:0]          i_lut_second_result,
    // Wide selectors
    input  wire logic                                   i_pair_lower_sel,
    input  wire logic                                   i_pair_upper_sel,
    input  wire logic                                   i_quad_sel,
    output      logic [lsm_pkg::LSM_LANES-1:0]          o_lut_main_result,
    output      logic                                   o_pair_combine_mux_lower,
    output      logic                                   o_pair_combine_mux_upper,
    output      logic                                   o_quad_combine_mux,
    // Carry chain
    input  wire logic [lsm_pkg::LSM_LANES-1:0]          i_bypass_lane,
    input  wire logic                                   i_carry_in_from_below,
    output      logic [lsm_pkg::LSM_LANES-1:0]          o_sum,
    output      logic [lsm_pkg::LSM_LANES-1:0]          o_carry,
    output      logic                                   o_carry_out_upward,
    // Slice flip-flops
    output      logic [lsm_pkg::LSM_LANES-1:0]          o_lane_q
);
    import lsm_pkg::*;

    // Reset synchroniser stages
    logic                      rst_meta_q;   // First stage, read only by next
    logic                      rst_b_q;      // Released reset used by design

    // Register file
    lsm_ctrl_t                 ctrl_q;       // Control word
    lsm_stat_t                 stat_w;       // Live status view

    // Bus slave state
    logic                      wr_pend_q;    // Write data phase pending
    logic                      rd_pend_q;    // Read wait state in progress
    logic [LSM_DEC_W-1:0]      addr_q;       // Captured address
    logic                      hready_q;     // Registered ready
    logic [LSM_DATA_W-1:0]     hrdata_q;     // Registered read data
    logic                      take_w;       // Address phase accepted

    // Shift storage, deliberately without reset
    logic [LSM_DEPTH-1:0]      srl_q [LSM_LANES];
    logic [LSM_LANES-1:0]      serial_w;     // Serial input per lane

    // Lookup table results and carry chain nets
    logic [LSM_LANES-1:0]      main_w;       // Main six-input result
    logic [LSM_LANES-1:0]      gen_w;        // Generate per position
    logic [LSM_LANES:0]        cin_w;        // Carry into each position
    logic [LSM_LANES-1:0]      sum_w;
    logic                      init_w;       // Carry into position zero
    logic [LSM_LANES-1:0]      lane_q;       // Slice flip-flops

    // Two-stage release of the asynchronous reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_q <= 1'b0;
            rst_b_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_b_q    <= rst_meta_q;
        end
    end

    // Accept an address phase only when selected, active and bus ready
    assign take_w = i_hsel && i_htrans[LSM_HTRANS_ACTIVE] && i_hready;

    // Address phase capture and ready generation
    // Reads take one wait state so read data always comes from a flop and
    // reflects a write finished in the cycle before.
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= '0;
            hready_q  <= 1'b1;
        end else begin
            if (rd_pend_q) begin
                // Wait state over, answer now
                rd_pend_q <= 1'b0;
                hready_q  <= 1'b1;
            end else if (take_w) begin
                addr_q    <= i_haddr[LSM_DEC_W-1:0];
                wr_pend_q <= i_hwrite;
                rd_pend_q <= !i_hwrite;
                hready_q  <= i_hwrite;
            end else if (i_hready) begin
                // Data phase ends with no new transfer
                wr_pend_q <= 1'b0;
            end
        end
    end

    // Control register write in the data phase
    // Only unspare fields store; other offsets drop the write silently.
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            ctrl_q <= lsm_ctrl_t'(LSM_CTRL_RESET);
        end else if (wr_pend_q && i_hready && addr_q == LSM_ADDR_CTRL) begin
            ctrl_q       <= lsm_ctrl_t'(i_hwdata);
            ctrl_q.spare <= '0;
        end
    end

    // Status view of the slice's own state
    always_comb begin
        stat_w              = '0;
        stat_w.sum          = sum_w;
        stat_w.carry        = cin_w[LSM_LANES:1];
        stat_w.lane_q       = lane_q;
        stat_w.cascade_last = srl_q[LSM_LANES-1][LSM_TOP_BIT];
    end

    // Read data loaded at the end of the wait state
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            hrdata_q <= LSM_RDATA_NONE;
        end else if (rd_pend_q) begin
            case (addr_q)
                LSM_ADDR_CTRL:   hrdata_q <= ctrl_q;
                LSM_ADDR_STATUS: hrdata_q <= stat_w;
                default:         hrdata_q <= LSM_RDATA_NONE;
            endcase
        end
    end

    assign o_hreadyout = hready_q;
    assign o_hrdata    = hrdata_q;
    assign o_hresp     = LSM_HRESP_OKAY;

    // Per-lane shift storage and lookup table result
    for (genvar l = 0; l < LSM_LANES; l++) begin : g_lane
        // Lane zero always takes the external serial bit; higher lanes take
        // the lane below's top bit when chained.
        if (l == 0) begin : g_first
            assign serial_w[l] = i_shift_in[l];
        end else begin : g_next
            assign serial_w[l] = ctrl_q.cascade_en ?
                                 srl_q[l-1][LSM_TOP_BIT] :
                                 i_shift_in[l];
        end

        // Storage has no reset term; only enabled shifts alter it
        always_ff @(posedge i_clk) begin
            if (i_shift_en) begin
                srl_q[l] <= {srl_q[l][LSM_DEPTH-2:0], serial_w[l]};
            end
        end

        // Main result: shift tap or 4:1 selector, both purely combinational
        // so a select change shows without waiting for a clock.
        always_comb begin
            o_tap[l] = srl_q[l][i_tap_sel[l]];
            if (ctrl_q.srl_mode[l]) begin
                main_w[l] = o_tap[l];
            end else begin
                main_w[l] = i_lut_data[l][i_lut_sel[l]];
            end
        end

        // Generate source: second result for multipliers, bypass for adders
        assign gen_w[l] = ctrl_q.gen_from_lut[l] ?
                          i_lut_second_result[l] : i_bypass_lane[l];

        // Carry select and sum XOR per position
        assign cin_w[l+1] = main_w[l] ? cin_w[l] : gen_w[l];
        assign sum_w[l]   = main_w[l] ^ cin_w[l];

        // Slice flip-flop with selectable source
        always_ff @(posedge i_clk or negedge rst_b_q) begin
            if (!rst_b_q) begin
                lane_q[l] <= 1'b0;
            end else begin
                case (ctrl_q.ff_src[2*l +: 2])
                    LSM_FF_LUT:    lane_q[l] <= main_w[l];
                    LSM_FF_SUM:    lane_q[l] <= sum_w[l];
                    LSM_FF_CARRY:  lane_q[l] <= cin_w[l+1];
                    default:       lane_q[l] <= i_bypass_lane[l];
                endcase
            end
        end
    end

    // Top bit of the last lane leaves as the cascade output
    assign o_cascade_shift_out = srl_q[LSM_LANES-1][LSM_TOP_BIT];

    // Pair and quad combining selectors; with chaining and taps these give
    // one addressable 128-stage delay.
    always_comb begin
        o_pair_combine_mux_lower = i_pair_lower_sel ? main_w[1] :
                                                      main_w[0];
        o_pair_combine_mux_upper = i_pair_upper_sel ? main_w[3] :
                                                      main_w[2];
        o_quad_combine_mux       = i_quad_sel ? o_pair_combine_mux_upper :
                                                o_pair_combine_mux_lower;
    end

    // Initial carry selection
    always_comb begin
        case (ctrl_q.init_sel)
            LSM_INIT_ZERO:     init_w = 1'b0;
            LSM_INIT_ONE:      init_w = 1'b1;
            LSM_INIT_BYPASS_A: init_w = i_bypass_lane[0];
            default:           init_w = i_carry_in_from_below;
        endcase
    end

    // Chain outputs: the top carry climbs to the slice above
    assign cin_w[0]           = init_w;
    assign o_sum              = sum_w;
    assign o_carry            = cin_w[LSM_LANES:1];
    assign o_carry_out_upward = cin_w[LSM_LANES];
    assign o_lut_main_result  = main_w;
    assign o_lane_q           = lane_q;

endmodule

//--- verif/lsm_next_slice.sv
// Model of the neighbouring slice that takes our cascade bit
`timescale 1ns/1ps
module lsm_next_slice (
    // Clock and shared shift enable
    input  wire logic       i_clk,
    input  wire logic       i_shift_en,
    // Serial input from the slice below
    input  wire logic       i_cascade_in,
    output      logic [7:0] o_bits
);
    // No reset: contents only move by enabled shifts, like ours
    always_ff @(posedge i_clk) begin
        if (i_shift_en) begin
            o_bits <= {o_bits[6:0], i_cascade_in};
        end
    end
endmodule

//--- verif/lsm_slice_monitor.sv
// Checker for shift, selector and carry outputs of the slice
`timescale 1ns/1ps
module lsm_slice_monitor (
    // Clock and reset
    input wire logic            i_clk,
    input wire logic            i_rst_b,
    // Shift storage
    input wire logic            i_shift_en,
    input wire logic [3:0]      i_shift_in,
    input wire logic [3:0][4:0] i_tap_sel,
    input wire logic [3:0]      o_tap,
    input wire logic            o_cascade_shift_out,
    // Selectors and carry chain
    input wire logic            i_pair_lower_sel,
    input wire logic            i_pair_upper_sel,
    input wire logic            i_quad_sel,
    input wire logic [3:0]      o_lut_main_result,
    input wire logic            o_pair_combine_mux_lower,
    input wire logic            o_pair_combine_mux_upper,
    input wire logic            o_quad_combine_mux,
    input wire logic [3:0]      o_sum,
    input wire logic [3:0]      o_carry,
    input wire logic            o_carry_out_upward
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Chain outputs; lane zero is skipped as its carry-in is hidden
    property p_carry_out_upward; o_carry_out_upward == o_carry[3]; endproperty
    a_carry_out_upward: assert property (p_carry_out_upward) else $error("upward carry wrong");
    property p_sum; o_sum[3:1] == (o_lut_main_result[3:1] ^ o_carry[2:0]);
    endproperty
    a_sum: assert property (p_sum) else $error("sum bit wrong");
    property p_prop;
        ((o_carry[3:1] ^ o_carry[2:0]) & o_lut_main_result[3:1]) == 3'h0;
    endproperty
    a_prop: assert property (p_prop) else $error("carry not passed");
    // Wide selectors
    property p_pair;
        o_pair_combine_mux_lower == o_lut_main_result[i_pair_lower_sel] &&
        o_pair_combine_mux_upper == o_lut_main_result[{1'b1, i_pair_upper_sel}];
    endproperty
    a_pair: assert property (p_pair) else $error("pair select wrong");
    property p_quad; o_quad_combine_mux == (i_quad_sel ?
        o_pair_combine_mux_upper : o_pair_combine_mux_lower); endproperty
    a_quad: assert property (p_quad) else $error("quad select wrong");
    // Shift storage: holds without enable, taps follow the shifts
    property p_cstay; !i_shift_en |=> $stable(o_cascade_shift_out); endproperty
    a_cstay: assert property (p_cstay) else $error("cascade moved");
    property p_top; i_tap_sel[3] == 5'h1f |-> o_tap[3] == o_cascade_shift_out;
    endproperty
    a_top: assert property (p_top) else $error("top bit mismatch");
    property p_tap0;
        i_shift_en ##1 i_tap_sel[0] == 5'h00 |-> o_tap[0] == $past(i_shift_in[0]);
    endproperty
    a_tap0: assert property (p_tap0) else $error("first stage wrong");
    property p_two; i_shift_en ##1 (i_shift_en && i_tap_sel[0] == 5'h01)
        |=> o_tap[0] == $past(i_shift_in[0], 2); endproperty
    a_two: assert property (p_two) else $error("two stage delay");
    property p_hold; !i_shift_en ##1 $stable(i_tap_sel) |-> $stable(o_tap);
    endproperty
    a_hold: assert property (p_hold) else $error("tap moved idle");
    // Main scenarios reached
    c_two: cover property (i_shift_en && i_tap_sel[0] == 5'h01);
    c_quad: cover property (o_quad_combine_mux && i_quad_sel);
    c_carry_out_upward: cover property (o_carry_out_upward);
endmodule
bind lsm_slice lsm_slice_monitor mon_u (.*);

//--- verif/lsm_slice_tb.sv
// Self-checking bench for the logic slice
`timescale 1ns/1ps
module lsm_slice_tb;
    import lsm_pkg::*;
    // One carry case: init source, generate source, operands, results
    typedef struct packed {
        logic [1:0] init;
        logic       gl;
        logic [3:0] p, g;
        logic       carry_in_from_below;
        logic [3:0] s, c;
    } lsm_row_t;
    localparam lsm_row_t ROWS [7] = '{
        '{2'h0, 1'h0, 4'hf, 4'h0, 1'h0, 4'hf, 4'h0},
        '{2'h0, 1'h0, 4'hf, 4'h0, 1'h1, 4'hf, 4'h0},
        '{2'h1, 1'h0, 4'hf, 4'h0, 1'h0, 4'h0, 4'hf},
        '{2'h1, 1'h0, 4'h0, 4'ha, 1'h0, 4'h5, 4'ha},
        '{2'h2, 1'h0, 4'he, 4'h1, 1'h0, 4'h1, 4'hf},
        '{2'h3, 1'h0, 4'h5, 4'h0, 1'h1, 4'h6, 4'h1},
        '{2'h0, 1'h1, 4'h0, 4'h6, 1'h0, 4'hc, 4'h6}};
    // Design inputs, all given a value at time zero
    logic i_clk = 0, i_rst_b = 0, i_hsel = 0, i_hwrite = 0, i_shift_en = 1;
    logic i_pair_lower_sel = 0, i_pair_upper_sel = 0, i_quad_sel = 0;
    logic i_carry_in_from_below = 0;
    logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0;
    logic [1:0]  i_htrans = 2'h0;
    logic [2:0]  i_hsize = 3'h2;
    logic [3:0]  i_shift_in = 4'h0, i_lut_second_result = 4'h0;
    logic [3:0]  i_bypass_lane = 4'h0;
    logic [3:0][4:0] i_tap_sel = 20'h0;
    logic [3:0][3:0] i_lut_data = 16'h0;
    logic [3:0][1:0] i_lut_sel = 8'h0;
    // Design outputs and the single slave's ready loop
    logic o_hreadyout, o_hresp, o_cascade_shift_out, o_quad_combine_mux;
    logic o_pair_combine_mux_lower, o_pair_combine_mux_upper;
    logic o_carry_out_upward;
    logic [31:0] o_hrdata;
    logic [3:0]  o_tap, o_lut_main_result, o_sum, o_carry, o_lane_q;
    logic [7:0]  nb_bits;
    wire         i_hready = o_hreadyout;
    int errors = 0, total_checks = 0;
    always #12.5 i_clk = ~i_clk;
    lsm_slice dut_u (.*);
    lsm_next_slice nb_u (.i_clk(i_clk), .i_shift_en(i_shift_en),
        .i_cascade_in(o_cascade_shift_out), .o_bits(nb_bits));
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Ready seen at the negedge is what the next rising edge samples
    task automatic rdy(output logic [31:0] q);
        int n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_hreadyout !== 1'b1 && n < 50);
        q = o_hrdata;
        if (n >= 50) begin
            errors++;
            finish_test();
        end
        @(posedge i_clk);
    endtask
    // One single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [31:0] a, d,
                       output logic [31:0] q);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_haddr <= a;
        i_htrans <= LSM_HTRANS_NONSEQ;
        i_hwrite <= wr;
        rdy(q);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        rdy(q);
    endtask
    // Exactly n enabled shifts of bit b into lane zero
    task automatic shift(input logic b, input int n);
        repeat (n) begin
            @(posedge i_clk);
            i_shift_en <= 1'b1;
            i_shift_in <= {3'h0, b};
        end
        @(posedge i_clk);
        i_shift_en <= 1'b0;
    endtask
    initial begin
        logic [31:0] q;
        logic [6:0]  k;
        lsm_row_t    r;
        repeat (2) @(posedge i_clk);
        chk(32'(o_lane_q), 32'h0);
        i_rst_b <= 1'b1;
        shift(1'b0, 40);
        bus(1'b0, 32'(LSM_ADDR_CTRL), 32'h0, q);
        chk(q, LSM_CTRL_RESET);
        bus(1'b1, 32'h8, 32'hffff_ffff, q);
        bus(1'b0, 32'h8, 32'h0, q);
        chk(q, LSM_RDATA_NONE);
        chk(32'(o_hresp), 32'(LSM_HRESP_OKAY));
        // Carry cases with slice flops taking the sums
        foreach (ROWS[i]) begin
            r = ROWS[i];
            bus(1'b1, 32'(LSM_ADDR_CTRL),
                {13'h0, 8'h55, 5'h0, {4{r.gl}}, r.init}, q);
            for (int l = 0; l < 4; l++) i_lut_data[l] <= {4{r.p[l]}};
            i_bypass_lane <= r.gl ? ~r.g : r.g;
            i_lut_second_result <= r.gl ? r.g : ~r.g;
            i_carry_in_from_below <= r.carry_in_from_below;
            repeat (2) @(posedge i_clk);
            @(negedge i_clk);
            chk(32'(o_sum), 32'(r.s));
            chk(32'(o_carry), 32'(r.c));
            chk(32'(o_carry_out_upward), 32'(r.c[3]));
            bus(1'b0, 32'(LSM_ADDR_STATUS), 32'h0, q);
            chk(q & 32'hfff, {20'h0, r.s, r.c, r.s});
        end
        // Sixteen-way selection, one live data bit at a time
        bus(1'b1, 32'(LSM_ADDR_CTRL), 32'h0, q);
        for (int j = 0; j < 16; j++) begin
            k = 7'(j);
            @(posedge i_clk);
            for (int l = 0; l < 4; l++)
                i_lut_data[l] <= (2'(l) == k[3:2]) ? 4'(1 << k[1:0]) : 4'h0;
            i_lut_sel <= {4{k[1:0]}};
            i_pair_lower_sel <= k[2];
            i_pair_upper_sel <= k[2];
            i_quad_sel <= k[3];
            @(negedge i_clk);
            chk(32'(o_lut_main_result), 32'(1 << k[3:2]));
            chk(32'(o_quad_combine_mux), 32'h1);
        end
        // Chained taps: one marked bit walked to stage 69, then swept
        bus(1'b1, 32'(LSM_ADDR_CTRL), 32'h0000_07c0, q);
        i_tap_sel <= {4{5'h01}};
        shift(1'b1, 1);
        shift(1'b0, 69);
        for (int j = 0; j < 128; j++) begin
            k = 7'(j);
            @(posedge i_clk);
            i_tap_sel <= {4{k[4:0]}};
            i_pair_lower_sel <= k[5];
            i_pair_upper_sel <= k[5];
            i_quad_sel <= k[6];
            @(negedge i_clk);
            chk(32'(o_quad_combine_mux), 32'(k == 7'h45));
        end
        shift(1'b0, 58);
        @(negedge i_clk);
        chk(32'(o_cascade_shift_out), 32'h1);
        // Reset in mid-run must leave the stored bits alone
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk(32'(o_lane_q), 32'h0);
        chk(32'(o_hreadyout), 32'h1);
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk(32'(o_cascade_shift_out), 32'h1);
        shift(1'b0, 1);
        @(negedge i_clk);
        chk(32'(nb_bits[0]), 32'h1);
        finish_test();
    end
endmodule
